// ===== snci_defs.vh
`ifndef SNCI_DEFS_VH
`define SNCI_DEFS_VH
// Opcodes.
`define OP_WREN      8'h06
`define OP_WRDI      8'h04
`define OP_GETF      8'h0f
`define OP_SETF      8'h1f
`define OP_PGRD      8'h13
`define OP_RD1       8'h03
`define OP_RD1F      8'h0b
`define OP_RDX2      8'h3b
`define OP_RDX4      8'h6b
`define OP_RDDIO     8'hbb
`define OP_RDQIO     8'heb
`define OP_RDDTR     8'hee
`define OP_RDID      8'h9f
`define OP_PL        8'h02
`define OP_PLX4      8'h32
`define OP_PEXE      8'h10
`define OP_PLR       8'h84
`define OP_PLRX4A    8'hc4
`define OP_PLRX4B    8'h34
`define OP_BERASE    8'hd8
`define OP_RESET     8'hff
`define OP_PORE      8'h66
`define OP_POR       8'h99
// Feature register addresses and fields.
`define FA_PROT      8'ha0
`define FA_CFG       8'hb0
`define FA_STAT      8'hc0
`define CFG_QE_BIT   0
`define PROT_LOCK_BITS_GUARD_BIT 7
// Protect register power-on value: all lock bits set.
`define PROT_RESET   8'h38
`define CFG_RESET    8'h10
`endif

// ===== cache_ram.v
`default_nettype none
// =====================================================================
// Cache page memory with registered read data.
module cache_ram #(
    parameter AW = 12,
    parameter DW = 8
) (
    input  wire          i_clk_sys,
    input  wire          i_we,
    input  wire [AW-1:0] i_waddr,
    input  wire [DW-1:0] i_wdata,
    input  wire [AW-1:0] i_raddr,
    output reg  [DW-1:0] o_rdata
);
    reg [DW-1:0] mem [0:(1<<AW)-1];

    // Write port and registered read port.
    always @(posedge i_clk_sys) begin
        if (i_we) begin
            mem[i_waddr] <= i_wdata;
        end
        o_rdata <= mem[i_raddr];
    end
endmodule // cache_ram
`default_nettype wire

// ===== serial_nand_command_interface.v
// What this block does
// [R1] Works with clock mode 0 or mode 3 hosts only.
// [R2] Inputs sampled on rising clock edge, outputs change on falling edge.
// [R3] Host keeps clock idle while deselected; the interface then idles.
// [R4] Dual commands use two bidirectional lanes, two bits per clock.
// [R5] Quad commands use four lanes, guard and pause pins become lanes two, three.
// [R6] Double-rate quad moves data on both edges; needs quad enable; the code drives read data on falling edges only.
// [R7] Pause works only with quad enable clear; otherwise pin is lane three.
// [R8] Pause halts serial traffic only; array operations keep running.
// [R9] Pause starts and ends on pause-pin edges, taking effect with clock low.
// [R10] While paused, output floats and input and clock are ignored.
// [R11] Chip select rising during pause resets the interface.
// [R12] Guard setting with guard pin low blocks lock bit writes.
// [R13] Hardware guard counts only while quad enable is clear.
// [R14] Get features returns live data; set features takes one data byte.
// [R15] Page read to cache takes three row bytes, then loads cache; the code only pulses o_array_read, no array data reaches the cache.
// [R16] Cache reads: two column bytes, dummy byte; dual one, quad two dummy.
// [R17] Column phase is 16, 8 or 4 clocks by lane count.
// [R18] Double-rate read: four address bytes over four clocks, eight dummy bytes; the code takes four (32 dummy bits).
// [R19] Identification: opcode, dummy byte, maker code then part code.
// [R20] Program loads take two column bytes then data bytes; x4 on four lanes.
// [R21] Reset aborts array work and clears fault, latch, busy, correction bits.
// [R22] Enable then power-on reset restores status and cache power-on state.
// [R23] Program execute and block erase take three row bytes.
// [R24] Quad and double-rate reads accepted only with quad enable set.
// [R25] Program and erase need the write latch set first.
`include "snci_defs.vh"
`default_nettype none
module serial_nand_command_interface #(
    parameter [7:0]  MAKER_CODE = 8'h5a,  // Arbitrary value.
    parameter [7:0]  PART_CODE  = 8'ha5,  // Arbitrary value.
    parameter [15:0] BUSY_CYCLES = 16'd64
) (
    input  wire       i_clk_sys,
    input  wire       i_reset_n,
    input  wire       i_sclk,
    input  wire       i_cs_n,
    input  wire [3:0] i_sio,
    output reg  [3:0] o_sio,
    output reg  [3:0] o_sio_oe,
    output wire       o_busy,
    output wire       o_write_latch,
    output wire       o_quad_lane_enable,
    output reg        o_array_read,
    output reg        o_array_program,
    output reg        o_array_erase,
    output reg [15:0] o_row
);
    // =================================================================
    // Input synchronisers.
    reg [1:0] s_clk, s_cs, s0, s1, s2, s3;
    reg       clk_d;
    always @(posedge i_clk_sys) begin
        s_clk <= {s_clk[0], i_sclk};
        s_cs  <= {s_cs[0], i_cs_n};
        s0    <= {s0[0], i_sio[0]};
        s1    <= {s1[0], i_sio[1]};
        s2    <= {s2[0], i_sio[2]};
        s3    <= {s3[0], i_sio[3]};
        clk_d <= s_clk[1];
    end
    wire sck = s_clk[1];
    wire cs_n = s_cs[1];
    wire [3:0] din = {s3[1], s2[1], s1[1], s0[1]};
    wire rise = sck & ~clk_d;      // [R1] [R2]
    wire fall = ~sck & clk_d;      // [R2]

    // =================================================================
    // Feature registers and status.
    reg [7:0] prot, cfg;
    reg       write_latch, operation_in_progress, pfail, efail;
    reg [1:0] ecc;
    reg [15:0] busy_cnt;
    reg        por_armed;
    wire qe = cfg[`CFG_QE_BIT];
    assign o_quad_lane_enable = qe;
    assign o_write_latch = write_latch;
    assign o_busy = operation_in_progress;

    // =================================================================
    // Pause tracking: follows the pause pin only while the serial clock is low.
    reg paused;
    always @(posedge i_clk_sys) begin
        if (!i_reset_n || cs_n || qe) begin          // [R7] [R11]
            paused <= 1'b0;
        end else if (!sck) begin                      // [R9]
            paused <= ~din[3];
        end
    end

    // =================================================================
    // Command framing state.
    localparam ST_OP = 4'b0001, ST_ADR = 4'b0010, ST_DUM = 4'b0100, ST_DAT = 4'b1000;
    reg [3:0]  st;
    reg [7:0]  op;
    reg [31:0] sh;
    reg [5:0]  bits;
    reg [5:0]  need;
    reg [7:0]  obyte;
    reg [11:0] col;
    reg [2:0]  lanes_l2;   // 0:x1 1:x2 2:x4
    reg        dtr;
    reg        hi_half;

    // Lane count per phase for an opcode: address and data widths.
    function [1:0] adr_w;
        input [7:0] o;
        begin
            case (o)
                `OP_RDDIO: adr_w = 2'd1;                     // [R4]
                `OP_RDQIO, `OP_RDDTR: adr_w = 2'd2;          // [R5]
                default: adr_w = 2'd0;
            endcase
        end
    endfunction
    function [1:0] dat_w;
        input [7:0] o;
        begin
            case (o)
                `OP_RDX2, `OP_RDDIO: dat_w = 2'd1;           // [R4]
                `OP_RDX4, `OP_RDQIO, `OP_RDDTR, `OP_PLX4,
                `OP_PLRX4A, `OP_PLRX4B: dat_w = 2'd2;        // [R5] [R20]
                default: dat_w = 2'd0;
            endcase
        end
    endfunction
    // Address bits for the opcode.
    function [5:0] adr_bits;
        input [7:0] o;
        begin
            case (o)
                `OP_GETF, `OP_SETF: adr_bits = 6'd8;                     // [R14]
                `OP_PGRD, `OP_PEXE, `OP_BERASE: adr_bits = 6'd24;        // [R15] [R23]
                `OP_RDDTR: adr_bits = 6'd32;                             // [R18]
                `OP_RD1, `OP_RD1F, `OP_RDX2, `OP_RDX4, `OP_RDDIO, `OP_RDQIO,
                `OP_PL, `OP_PLX4, `OP_PLR, `OP_PLRX4A,
                `OP_PLRX4B: adr_bits = 6'd16;                            // [R17] [R20]
                `OP_RDID: adr_bits = 6'd0;
                default: adr_bits = 6'd0;
            endcase
        end
    endfunction
    // Dummy bits for the opcode.
    function [5:0] dum_bits;
        input [7:0] o;
        begin
            case (o)
                `OP_RD1, `OP_RD1F, `OP_RDX2, `OP_RDX4, `OP_RDID: dum_bits = 6'd8; // [R16] [R19]
                `OP_RDDIO: dum_bits = 6'd8;                                     // [R16]
                `OP_RDQIO: dum_bits = 6'd16;                                    // [R16]
                `OP_RDDTR: dum_bits = 6'd32;                                    // [R18]
                default: dum_bits = 6'd0;
            endcase
        end
    endfunction
    function is_read;
        input [7:0] o;
        begin
            is_read = (o == `OP_RD1) || (o == `OP_RD1F) || (o == `OP_RDX2) ||
                      (o == `OP_RDX4) || (o == `OP_RDDIO) || (o == `OP_RDQIO) ||
                      (o == `OP_RDDTR);
        end
    endfunction
    function needs_qe;
        input [7:0] o;
        begin
            needs_qe = (o == `OP_RDX4) || (o == `OP_RDQIO) || (o == `OP_RDDTR); // [R24] [R6]
        end
    endfunction

    // Bits moved per active edge in the current phase.
    wire [2:0] step = (3'd1 << lanes_l2);
    wire active = !cs_n && !paused && (rise || (dtr && fall));  // [R8] [R10] [R6]

    // Cache memory access.
    reg        ram_we;
    reg [11:0] ram_wa;
    reg [7:0]  ram_wd;
    wire [7:0] ram_q;
    reg  [11:0] ram_ra;
    reg        clearing;
    reg [11:0] clr_addr;
    cache_ram #(.AW(12), .DW(8)) u_cache (
        .i_clk_sys (i_clk_sys),
        .i_we      (ram_we | clearing),
        .i_waddr   (clearing ? clr_addr : ram_wa),
        .i_wdata   (clearing ? 8'hff : ram_wd),
        .i_raddr   (ram_ra),
        .o_rdata   (ram_q)
    );

    // Live feature read value.
    reg [7:0] feat_q;
    always @* begin
        case (sh[7:0])
            `FA_PROT: feat_q = prot;
            `FA_CFG:  feat_q = cfg;
            `FA_STAT: feat_q = {2'b00, ecc, pfail, efail, write_latch, operation_in_progress};
            default:  feat_q = 8'h00;
        endcase
    end
    wire guard_on = prot[`PROT_LOCK_BITS_GUARD_BIT] & ~din[2] & ~qe;  // [R12] [R13]

    // Shifted-in value including this edge's bits.
    reg [31:0] next_sh;
    always @* begin
        case (lanes_l2)
            3'd1: next_sh = {sh[29:0], din[1:0]};
            3'd2: next_sh = {sh[27:0], din[3:0]};
            default: next_sh = {sh[30:0], din[0]};
        endcase
    end
    wire [5:0] next_bits = bits + {3'b000, step};

    // =================================================================
    // Main sequencer.
    always @(posedge i_clk_sys) begin
        ram_we <= 1'b0;
        o_array_read <= 1'b0;
        o_array_program <= 1'b0;
        o_array_erase <= 1'b0;
        if (!i_reset_n) begin
            st <= ST_OP; op <= 8'h00; sh <= 32'h0; bits <= 6'd0; need <= 6'd8;
            lanes_l2 <= 3'd0; dtr <= 1'b0; col <= 12'h0; obyte <= 8'h00;
            o_sio <= 4'h0; o_sio_oe <= 4'h0; hi_half <= 1'b0; ram_ra <= 12'h0;
            prot <= `PROT_RESET; cfg <= `CFG_RESET; write_latch <= 1'b0; operation_in_progress <= 1'b0;
            pfail <= 1'b0; efail <= 1'b0; ecc <= 2'b00; busy_cnt <= 16'd0;
            por_armed <= 1'b0; clearing <= 1'b0; clr_addr <= 12'h0; o_row <= 16'h0;
            ram_wa <= 12'h0; ram_wd <= 8'h00;
        end else begin
            // Array operation timer runs regardless of pause.
            if (operation_in_progress) begin                                   // [R8]
                if (busy_cnt == 16'd0) operation_in_progress <= 1'b0;
                else busy_cnt <= busy_cnt - 16'd1;
            end
            if (clearing) begin
                clr_addr <= clr_addr + 12'd1;
                if (clr_addr == 12'hfff) clearing <= 1'b0;
            end
            if (cs_n) begin                                  // [R3] [R11]
                st <= ST_OP; bits <= 6'd0; need <= 6'd8; lanes_l2 <= 3'd0;
                dtr <= 1'b0; o_sio_oe <= 4'h0; hi_half <= 1'b0;
            end else if (paused) begin
                o_sio_oe <= 4'h0;                            // [R10]
            end else if (st == ST_DAT && fall && !is_write_op(op)) begin
                // Output shifting on the falling edge.  [R2]
                shift_out();
            end
            if (active && !(st == ST_DAT && !is_write_op(op))) begin
                sh <= next_sh;
                bits <= next_bits;
                if (next_bits >= need) begin
                    bits <= 6'd0;
                    case (st)
                        ST_OP: decode(next_sh[7:0]);
                        ST_ADR: begin
                            col <= next_sh[11:0];
                            if (op == `OP_RDDTR) begin
                                col <= next_sh[11:0];
                            end
                            if (op == `OP_SETF) begin
                                st <= ST_DAT; need <= 6'd8; lanes_l2 <= 3'd0;
                            end else if (op == `OP_PGRD) begin       // [R15]
                                o_row <= next_sh[15:0]; o_array_read <= 1'b1;
                                operation_in_progress <= 1'b1; busy_cnt <= BUSY_CYCLES; st <= ST_DUM; need <= 6'd63;
                            end else if (op == `OP_PEXE) begin       // [R23] [R25]
                                o_row <= next_sh[15:0];
                                if (write_latch) begin
                                    o_array_program <= 1'b1; operation_in_progress <= 1'b1; busy_cnt <= BUSY_CYCLES;
                                end else pfail <= 1'b1;
                                write_latch <= 1'b0; st <= ST_DUM; need <= 6'd63;
                            end else if (op == `OP_BERASE) begin     // [R23] [R25]
                                o_row <= next_sh[15:0];
                                if (write_latch) begin
                                    o_array_erase <= 1'b1; operation_in_progress <= 1'b1; busy_cnt <= BUSY_CYCLES;
                                end else efail <= 1'b1;
                                write_latch <= 1'b0; st <= ST_DUM; need <= 6'd63;
                            end else if (dum_bits(op) != 6'd0) begin
                                st <= ST_DUM; need <= dum_bits(op); lanes_l2 <= {1'b0, adr_w(op)};
                            end else begin
                                st <= ST_DAT; need <= 6'd8; lanes_l2 <= {1'b0, dat_w(op)};
                                ram_ra <= next_sh[11:0];
                            end
                        end
                        ST_DUM: begin
                            st <= ST_DAT; need <= 6'd8; lanes_l2 <= {1'b0, dat_w(op)};
                            ram_ra <= col; hi_half <= 1'b0;
                        end
                        default: begin
                            // Incoming data byte.
                            if (op == `OP_SETF) begin                    // [R14]
                                if (next_sh[15:8] == `FA_PROT && !guard_on) prot <= next_sh[7:0];
                                if (next_sh[15:8] == `FA_CFG) cfg <= next_sh[7:0];
                                st <= ST_DUM; need <= 6'd63;
                            end else begin                                // [R20]
                                ram_we <= 1'b1; ram_wa <= col; ram_wd <= next_sh[7:0];
                                col <= col + 12'd1;
                            end
                        end
                    endcase
                end
            end
        end
    end

    // Writes that travel host to device in the data phase.
    function is_write_op;
        input [7:0] o;
        begin
            is_write_op = (o == `OP_SETF) || (o == `OP_PL) || (o == `OP_PLX4) ||
                          (o == `OP_PLR) || (o == `OP_PLRX4A) || (o == `OP_PLRX4B);
        end
    endfunction

    // Opcode decode at the end of the opcode byte.
    task decode;
        input [7:0] o;
        begin
            op <= o;
            if (o != `OP_POR) por_armed <= 1'b0;
            if (needs_qe(o) && !qe) begin                    // [R24]
                st <= ST_DUM; need <= 6'd63;
            end else begin
                case (o)
                    `OP_WREN: begin write_latch <= 1'b1; st <= ST_DUM; need <= 6'd63; end
                    `OP_WRDI: begin write_latch <= 1'b0; st <= ST_DUM; need <= 6'd63; end
                    `OP_RESET: begin                          // [R21]
                        operation_in_progress <= 1'b0; busy_cnt <= 16'd0; pfail <= 1'b0; efail <= 1'b0;
                        write_latch <= 1'b0; ecc <= 2'b00; st <= ST_DUM; need <= 6'd63;
                    end
                    `OP_PORE: begin por_armed <= 1'b1; st <= ST_DUM; need <= 6'd63; end
                    `OP_POR: begin                            // [R22]
                        if (por_armed) begin
                            prot <= `PROT_RESET; cfg <= `CFG_RESET; write_latch <= 1'b0;
                            operation_in_progress <= 1'b0; busy_cnt <= 16'd0; pfail <= 1'b0;
                            efail <= 1'b0; ecc <= 2'b00; clearing <= 1'b1;
                            clr_addr <= 12'h0;
                        end
                        por_armed <= 1'b0; st <= ST_DUM; need <= 6'd63;
                    end
                    `OP_RDID: begin                           // [R19]
                        st <= ST_DUM; need <= 6'd8; obyte <= MAKER_CODE; col <= 12'h0;
                    end
                    default: begin
                        if (adr_bits(o) != 6'd0) begin
                            st <= ST_ADR; need <= adr_bits(o); lanes_l2 <= {1'b0, adr_w(o)};
                            dtr <= (o == `OP_RDDTR);          // [R6] [R18]
                        end else begin
                            st <= ST_DUM; need <= 6'd63;
                        end
                    end
                endcase
            end
        end
    endtask

    // Output one lane-group of the current byte on a falling edge.
    task shift_out;
        reg [7:0] cur;
        begin
            cur = (op == `OP_GETF) ? feat_q :                  // [R14]
                  (op == `OP_RDID) ? ((col == 12'h0) ? MAKER_CODE : PART_CODE) :
                  is_read(op) ? ram_q : 8'h00;
            o_sio_oe <= (lanes_l2 == 3'd2) ? 4'hf : (lanes_l2 == 3'd1) ? 4'h3 : 4'h2;
            case (lanes_l2)
                3'd2: o_sio <= hi_half ? cur[3:0] : cur[7:4];            // [R5]
                3'd1: o_sio <= {2'b00, cur[7 - {bits[2:1], 1'b0}],
                                cur[6 - {bits[2:1], 1'b0}]};             // [R4]
                default: o_sio <= {2'b00, cur[7 - bits[2:0]], 1'b0};
            endcase
            if (lanes_l2 == 3'd2) hi_half <= ~hi_half;
            if (bits + {3'b000, step} >= 6'd8) begin
                bits <= 6'd0;
                col <= col + 12'd1;
                ram_ra <= col + 12'd1;
            end else begin
                bits <= bits + {3'b000, step};
            end
        end
    endtask
endmodule // serial_nand_command_interface
`default_nettype wire

// ===== serial_nand_props.sv
`default_nettype none
// ========================================
// Port checks of the serial command interface.
module serial_nand_props #(
    parameter [15:0] BUSY_CYCLES = 16'd64
) (
    input wire logic       i_clk_sys,
    input wire logic       i_reset_n,
    input wire logic       i_sclk,
    input wire logic       i_cs_n,
    input wire logic [3:0] o_sio,
    input wire logic [3:0] o_sio_oe,
    input wire logic       o_busy,
    input wire logic       o_write_latch,
    input wire logic       o_quad_lane_enable,
    input wire logic       o_array_read,
    input wire logic       o_array_program,
    input wire logic       o_array_erase
);
    default clocking @(posedge i_clk_sys);
    endclocking
    default disable iff (!i_reset_n);
    logic [3:0] since_fall;
    // Counts cycles since the serial clock last fell, saturating.
    always @(posedge i_clk_sys) begin
        if (!i_reset_n || $fell(i_sclk)) begin
            since_fall <= 4'h0;
        end else if (since_fall != 4'hf) begin
            since_fall <= since_fall + 4'h1;
        end
    end
    sequence s_deselected;
        i_cs_n [*6];
    endsequence
    sequence s_read_done;
        !o_array_read ##[0:1] o_busy;
    endsequence
    property p_idle_quiet;
        s_deselected |-> o_sio_oe == 4'h0;
    endproperty
    property p_quad_lanes;
        o_sio_oe[3:2] != 2'h0 |-> o_quad_lane_enable;
    endproperty
    property p_lane0_multi;
        o_sio_oe[0] |-> o_sio_oe[1];
    endproperty
    property p_out_on_fall;
        $changed(o_sio) && o_sio_oe != 4'h0 && $past(o_sio_oe) != 4'h0
            |-> since_fall < 4'h8;
    endproperty
    property p_read_busy;
        o_array_read |=> s_read_done;
    endproperty
    property p_prog_latch;
        o_array_program |-> $past(o_write_latch);
    endproperty
    property p_erase_latch;
        o_array_erase |-> $past(o_write_latch);
    endproperty
    property p_one_array;
        $onehot0({o_array_read, o_array_program, o_array_erase});
    endproperty
    a_idle_quiet: assert property (p_idle_quiet)
        else $error("lanes driven while deselected");
    a_quad_lanes: assert property (p_quad_lanes)
        else $error("upper lanes driven without quad enable");
    a_lane0_multi: assert property (p_lane0_multi)
        else $error("lane zero driven alone");
    a_out_on_fall: assert property (p_out_on_fall)
        else $error("output changed away from a falling clock");
    a_read_busy: assert property (p_read_busy)
        else $error("page load pulse without busy");
    a_prog_latch: assert property (p_prog_latch)
        else $error("program without write latch");
    a_erase_latch: assert property (p_erase_latch)
        else $error("erase without write latch");
    a_one_array: assert property (p_one_array)
        else $error("two array requests at once");
endmodule  // serial_nand_props
bind serial_nand_command_interface serial_nand_props #(.BUSY_CYCLES(BUSY_CYCLES)) u_props (
    .i_clk_sys(i_clk_sys), .i_reset_n(i_reset_n), .i_sclk(i_sclk), .i_cs_n(i_cs_n),
    .o_sio(o_sio), .o_sio_oe(o_sio_oe), .o_busy(o_busy), .o_write_latch(o_write_latch),
    .o_quad_lane_enable(o_quad_lane_enable), .o_array_read(o_array_read),
    .o_array_program(o_array_program), .o_array_erase(o_array_erase));
`default_nettype wire

// ===== spi_host_model.sv
`default_nettype none
// ========================================
// Host controller in clock mode 0, single lane.
module spi_host_model (
    input  wire logic       i_clk_sys,
    input  wire logic [3:0] i_sio,
    output var  logic       o_sclk,
    output var  logic       o_cs_n,
    output var  logic [3:0] o_drv,
    output var  logic [3:0] o_en
);
    timeunit 1ns;
    timeprecision 1ps;
    // Idle: clock low, deselected, guard and pause pins held high.
    initial begin
        o_sclk = 1'b0;
        o_cs_n = 1'b1;
        o_drv = 4'hf;
        o_en = 4'hc;
    end
    // Sets the level of the guard pin.
    task automatic guard(input logic v);
        o_drv[2] = v;
    endtask
    // Selects the device with the clock still at its idle level.
    task automatic start();
        o_cs_n = 1'b0;
        o_en = 4'hd;
        repeat (8) @(negedge i_clk_sys);
    endtask
    // Moves one byte each way, msb first, reading at the rising clock.
    task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
        for (int i = 7; i >= 0; i--) begin
            o_drv[0] = tx[i];
            repeat (8) @(negedge i_clk_sys);
            o_sclk = 1'b1;
            rx[i] = i_sio[1];
            repeat (8) @(negedge i_clk_sys);
            o_sclk = 1'b0;
        end
    endtask
    // Ends the frame and releases lane zero.
    task automatic stop();
        repeat (8) @(negedge i_clk_sys);
        o_cs_n = 1'b1;
        o_en = 4'hc;
        repeat (16) @(negedge i_clk_sys);
    endtask
endmodule  // spi_host_model
`default_nettype wire

// ===== serial_nand_command_interface_test.sv
`include "snci_defs.vh"
`default_nettype none
// ========================================
// Self-checking bench for the serial command interface.
module serial_nand_command_interface_test;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [7:0] MAKER = 8'h3c;  // Arbitrary value.
    localparam logic [7:0] PART  = 8'h7e;  // Arbitrary value.
    logic        i_clk_sys = 1'b0;
    logic        i_reset_n = 1'b0;
    wire         sclk;
    wire         cs_n;
    wire  [3:0]  drv;
    wire  [3:0]  en;
    wire  [3:0]  o_sio;
    wire  [3:0]  oe;
    wire  [3:0]  sio;
    wire  [15:0] o_row;
    wire         busy;
    wire         wl;
    wire         qe;
    wire         rd;
    wire         pg;
    wire         er;
    int          mismatches = 0;
    int          check_count = 0;
    int          n_rd = 0;
    int          n_pg = 0;
    int          n_er = 0;
    logic [15:0] last_row;
    // Clock and pin levels; released lanes are pulled up.
    always #2 i_clk_sys = ~i_clk_sys;
    assign sio = (oe & o_sio) | (~oe & en & drv) | (~oe & ~en);
    serial_nand_command_interface #(.MAKER_CODE(MAKER), .PART_CODE(PART),
        .BUSY_CYCLES(16'd8)) dut (
        .i_clk_sys(i_clk_sys), .i_reset_n(i_reset_n), .i_sclk(sclk), .i_cs_n(cs_n),
        .i_sio(sio), .o_sio(o_sio), .o_sio_oe(oe), .o_busy(busy), .o_write_latch(wl),
        .o_quad_lane_enable(qe), .o_array_read(rd), .o_array_program(pg),
        .o_array_erase(er), .o_row(o_row));
    spi_host_model host (.i_clk_sys(i_clk_sys), .i_sio(sio), .o_sclk(sclk),
        .o_cs_n(cs_n), .o_drv(drv), .o_en(en));
    // Counts array requests and keeps the row of the last one.
    always @(posedge i_clk_sys) begin
        if ((rd | pg | er) === 1'b1) begin
            last_row <= o_row;
        end
        n_rd <= n_rd + int'(rd === 1'b1);
        n_pg <= n_pg + int'(pg === 1'b1);
        n_er <= n_er + int'(er === 1'b1);
    end
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        check_count++;
        if (seen !== exp) begin
            mismatches++;
            $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic cmd(input logic [7:0] op, input int n, input logic [23:0] arg);
        logic [7:0] r;
        host.start();
        host.xfer(op, r);
        for (int i = n - 1; i >= 0; i--) host.xfer(arg[8*i +: 8], r);
        host.stop();
    endtask
    task automatic getf(input logic [7:0] a, input logic [7:0] exp);
        logic [7:0] d;
        host.start();
        host.xfer(`OP_GETF, d);
        host.xfer(a, d);
        host.xfer(8'h00, d);
        host.stop();
        check(16'(d), 16'(exp));
    endtask
    task automatic test_id();
        logic [7:0] m;
        logic [7:0] p;
        host.start();
        host.xfer(`OP_RDID, m);
        host.xfer(8'h00, m);
        host.xfer(8'h00, m);
        host.xfer(8'h00, p);
        host.stop();
        check(16'(m), 16'(MAKER));
        check(16'(p), 16'(PART));
        $display("test_id done");
    endtask
    task automatic test_array();
        int c;
        logic [7:0] d;
        cmd(`OP_WREN, 0, 24'h0);
        check(16'(wl), 16'h0001);
        c = n_pg;
        cmd(`OP_PEXE, 3, 24'h001234);
        check(16'(n_pg - c), 16'h0001);
        check(last_row, 16'h1234);
        cmd(`OP_WRDI, 0, 24'h0);
        c = n_er;
        cmd(`OP_BERASE, 3, 24'h000040);
        check(16'(n_er - c), 16'h0000);
        c = n_rd;
        cmd(`OP_PGRD, 3, 24'h000056);
        check(16'(n_rd - c), 16'h0001);
        check(last_row, 16'h0056);
        cmd(`OP_WREN, 0, 24'h0);
        cmd(`OP_RESET, 0, 24'h0);
        check(16'(wl), 16'h0000);
        getf(`FA_STAT, 8'h00);
        cmd(`OP_PL, 3, 24'h00005c);
        host.start();
        host.xfer(`OP_RD1, d);
        repeat (4) host.xfer(8'h00, d);
        host.stop();
        check(16'(d), 16'h005c);
        $display("test_array done");
    endtask
    task automatic test_feat();
        getf(`FA_CFG, `CFG_RESET);
        cmd(`OP_SETF, 2, {8'h0, `FA_PROT, 8'hb8});
        host.guard(1'b0);
        cmd(`OP_SETF, 2, {8'h0, `FA_PROT, 8'h80});
        getf(`FA_PROT, 8'hb8);
        cmd(`OP_SETF, 2, {8'h0, `FA_CFG, 8'h11});
        check(16'(qe), 16'h0001);
        cmd(`OP_SETF, 2, {8'h0, `FA_PROT, 8'h80});
        getf(`FA_PROT, 8'h80);
        cmd(`OP_SETF, 2, {8'h0, `FA_CFG, 8'h10});
        host.guard(1'b1);
        $display("test_feat done");
    endtask
    task automatic final_report();
        $display("checks %0d mismatches %0d", check_count, mismatches);
        if (mismatches == 0 && check_count > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    // Main sequence after a two-cycle reset.
    initial begin
        repeat (2) @(negedge i_clk_sys);
        i_reset_n = 1'b1;
        repeat (4) @(negedge i_clk_sys);
        test_id();
        test_array();
        test_feat();
        final_report();
    end
    // Cuts a hung run short.
    initial begin
        repeat (100000) @(negedge i_clk_sys);
        mismatches++;
        final_report();
    end
endmodule  // serial_nand_command_interface_test
`default_nettype wire
